// ===== src/timer8_waveform_generator.sv
// Counter, compare unit, wave output register and pin override of an 8-bit timer.
// Assumes an AHB-Lite master on hclk; the pin buffer resolves out/oe outside.
`timescale 1ns/1ps
`default_nettype none

module timer8_waveform_generator
  import timer8_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire timer8_pkg::ahb_req_t ahb_req,
  output timer8_pkg::ahb_rsp_t ahb_rsp,
  output timer8_pkg::pin_t pin
);

  typedef struct packed {
    logic [9:0] pre;
    logic [1:0] mode;
    logic [1:0] com;
    logic [2:0] cs;
    logic [7:0] count;
    logic [7:0] cmp_buf;
    logic [7:0] cmp_act;
    logic ovf;
    logic cmpf;
    logic wave;
    logic port_out;
    logic dir;
    logic block;
    bus_phase_t phase;
    logic write;
    logic [4:0] addr;
    logic hreadyout;
    logic [31:0] hrdata;
    logic pin_out;
    logic pin_oe;
  } state_t;

  localparam state_t STATE_RST = '{
    pre: PRE_RST, mode: MODE_NORMAL, com: COM_OFF, cs: CS_NONE,
    count: REG_RST, cmp_buf: REG_RST, cmp_act: REG_RST,
    ovf: 1'b0, cmpf: 1'b0, wave: 1'b0, port_out: 1'b0, dir: 1'b0,
    block: 1'b0, phase: BUS_IDLE, write: 1'b0, addr: CTRL_OFS,
    hreadyout: 1'b1, hrdata: RDATA_RST, pin_out: 1'b0, pin_oe: 1'b0};

  state_t q;
  state_t d;

  logic tick;
  logic match;
  logic at_max;
  logic pwm;
  logic wr_data;
  logic wr_ctrl;
  logic wr_count;
  logic wr_cmp;
  logic wr_stat;
  logic wr_port;
  logic force_w;
  logic [7:0] wd;

  ////////////////////////////////////////////////////////////////////////////
  // Tick and compare decode

  always_comb begin
    case (q.cs)
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = (q.pre & DIV8_LAST) == DIV8_LAST;
      CS_DIV64: tick = (q.pre & DIV64_LAST) == DIV64_LAST;
      CS_DIV256: tick = (q.pre & DIV256_LAST) == DIV256_LAST;
      CS_DIV1024: tick = (q.pre & DIV1024_LAST) == DIV1024_LAST;
      default: tick = 1'b0;
    endcase
  end

  // A count write masks the match at the following tick
  assign match = (q.count == q.cmp_act) && !q.block;
  assign at_max = q.count == COUNT_MAX;
  assign pwm = q.mode[0];
  assign wd = ahb_req.hwdata[7:0];
  assign wr_data = (q.phase == BUS_DATA) && q.write;
  assign wr_ctrl = wr_data && (q.addr == CTRL_OFS);
  assign wr_count = wr_data && (q.addr == COUNT_OFS);
  assign wr_cmp = wr_data && (q.addr == COMPARE_OFS);
  assign wr_stat = wr_data && (q.addr == STATUS_OFS);
  assign wr_port = wr_data && (q.addr == PORT_OFS);
  // Strobe is judged against the mode being written in the same access
  assign force_w = wr_ctrl && wd[CTRL_FORCE_BIT] && !wd[CTRL_MODE_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    d.pre = 10'(q.pre + 10'h001);

    // Software side: control writes and write-one-to-clear flags
    if (wr_ctrl) begin
      d.mode = wd[CTRL_MODE_LSB +: 2];
      d.com = wd[CTRL_COM_LSB +: 2];
      d.cs = wd[CTRL_CS_LSB +: 3];
    end
    if (wr_cmp) begin
      d.cmp_buf = wd;
    end
    if (wr_port) begin
      d.port_out = wd[PORT_OUT_BIT];
      d.dir = wd[PORT_DIR_BIT];
    end
    if (wr_stat && wd[STAT_OVF_BIT]) begin
      d.ovf = 1'b0;
    end
    if (wr_stat && wd[STAT_CMP_BIT]) begin
      d.cmpf = 1'b0;
    end

    // Timer side, later in the block so a hardware set wins over a clear
    if (tick) begin
      d.block = 1'b0;
      case (q.mode)
        MODE_CLEAR: begin
          // Compare below count misses and rolls over first
          d.count = match ? COUNT_BOTTOM : 8'(q.count + 8'h01);
          if (at_max) begin
            d.ovf = 1'b1;
          end
        end
        MODE_FAST: begin
          d.count = at_max ? COUNT_BOTTOM : 8'(q.count + 8'h01);
          if (at_max) begin
            d.ovf = 1'b1;
            d.cmp_act = q.cmp_buf;
          end
        end
        default: begin
          d.count = 8'(q.count + 8'h01);
          if (at_max) begin
            d.ovf = 1'b1;
          end
        end
      endcase
      if (match) begin
        d.cmpf = 1'b1;
        d.wave = wave_act(q.com, q.wave);
      end
      // Bottom after match, so compare at max gives a flat level under clear and set (toggle still toggles)
      if ((q.mode == MODE_FAST) && at_max) begin
        if (q.com == COM_CLEAR) begin
          d.wave = 1'b1;
        end else if (q.com == COM_SET) begin
          d.wave = 1'b0;
        end
      end
    end

    // Forced compare changes only the wave register
    if (force_w) begin
      d.wave = wave_act(wd[CTRL_COM_LSB +: 2], d.wave);
    end

    // Software count write has the last word
    if (wr_count) begin
      d.count = wd;
      d.block = 1'b1;
    end

    // Non-PWM modes use the written compare value at once
    if (!d.mode[0]) begin
      d.cmp_act = d.cmp_buf;
    end

    // Pin override
    d.pin_out = (d.com != COM_OFF) ? d.wave : d.port_out;
    d.pin_oe = d.dir;

    // Bus slave: one wait state so a read always sees the prior write
    case (q.phase)
      BUS_IDLE: begin
        if (ahb_req.hsel && (ahb_req.htrans == HTRANS_NONSEQ) && ahb_req.hready) begin
          d.phase = BUS_DATA;
          d.hreadyout = 1'b0;
          d.write = ahb_req.hwrite;
          d.addr = ahb_req.haddr[4:0];
        end
      end
      BUS_DATA: begin
        d.phase = BUS_IDLE;
        d.hreadyout = 1'b1;
        if (!q.write) begin
          case (q.addr)
            CTRL_OFS: d.hrdata = {24'h00_0000, 1'b0, q.cs, q.com, q.mode};
            COUNT_OFS: d.hrdata = {24'h00_0000, q.count};
            COMPARE_OFS: d.hrdata = {24'h00_0000, q.cmp_buf};
            STATUS_OFS: d.hrdata = {29'h0000_0000, q.wave, q.cmpf, q.ovf};
            PORT_OFS: d.hrdata = {30'h0000_0000, q.dir, q.port_out};
            default: d.hrdata = RDATA_RST;
          endcase
        end
      end
      default: begin
        d.phase = BUS_IDLE;
        d.hreadyout = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign ahb_rsp = '{hreadyout: q.hreadyout, hresp: HRESP_OKAY, hrdata: q.hrdata};
  assign pin = '{wave_pin_out: q.pin_out, wave_pin_oe: q.pin_oe};

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_addr_taken;
    ahb_req.hsel && (ahb_req.htrans == HTRANS_NONSEQ) && ahb_req.hready && q.hreadyout;
  endsequence

  sequence s_one_wait;
    !q.hreadyout ##1 q.hreadyout;
  endsequence

  bus_answer_a: assert property (s_addr_taken |=> s_one_wait)
    else $error("bus answer not after exactly one wait state");

  pin_mux_a: assert property (##1 (pin.wave_pin_out == (($past(d.com) != COM_OFF) ? q.wave : q.port_out)))
    else $error("pin output does not follow override selection");

  pin_dir_a: assert property (wr_port |=> pin.wave_pin_oe == $past(wd[PORT_DIR_BIT]))
    else $error("pin enable does not follow direction bit");

  com_hold_a: assert property ((q.com == COM_OFF) && !force_w && !wr_ctrl |=> $stable(q.wave))
    else $error("wave changed with output action off");

  normal_ovf_a: assert property (tick && (q.mode == MODE_NORMAL) && at_max && !wr_count && !wr_ctrl
      |=> q.ovf && (q.count == COUNT_BOTTOM))
    else $error("normal mode wrap did not set overflow");

  clear_top_a: assert property (tick && (q.mode == MODE_CLEAR) && match && !wr_count && !wr_ctrl
      |=> (q.count == COUNT_BOTTOM) && q.cmpf)
    else $error("clear-on-match did not clear count and flag");

  fast_wrap_a: assert property (tick && (q.mode == MODE_FAST) && at_max && !wr_count && !wr_ctrl
      |=> (q.count == COUNT_BOTTOM) && (q.cmp_act == $past(q.cmp_buf)) && q.ovf)
    else $error("fast PWM boundary wrong");

  fast_bottom_a: assert property (tick && (q.mode == MODE_FAST) && at_max && (q.com == COM_CLEAR)
      && !force_w |=> q.wave)
    else $error("fast PWM bottom did not set wave");

  force_flag_a: assert property (force_w && !tick && !wr_count |=> $stable(q.cmpf) && $stable(q.count)
      && (q.wave == wave_act($past(wd[CTRL_COM_LSB +: 2]), $past(q.wave))))
    else $error("forced compare did more than update wave");

  idle_count_a: assert property (!tick && !wr_count |=> $stable(q.count))
    else $error("count moved without a tick");

  // Block stays set until a tick passes, however slow the prescaler runs
  count_prio_a: assert property (wr_count |=> (q.count == $past(wd)) && q.block)
    else $error("count write lost to counting");

endmodule // timer8_waveform_generator

`default_nettype wire

// ===== src/timer8_pkg.sv
// Constants, register map and carrier types of the 8-bit timer waveform block.
// Assumes a single 50 MHz clock and an AHB-Lite master issuing single word transfers.
package timer8_pkg;

  localparam int CLK_MHZ = 50;

  // Register byte offsets
  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] COUNT_OFS = 5'h04;
  localparam logic [4:0] COMPARE_OFS = 5'h08;
  localparam logic [4:0] STATUS_OFS = 5'h0C;
  localparam logic [4:0] PORT_OFS = 5'h10;

  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_COM_LSB = 2;
  localparam int CTRL_CS_LSB = 4;
  localparam int CTRL_FORCE_BIT = 7;
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_CMP_BIT = 1;
  localparam int STAT_WAVE_BIT = 2;
  localparam int PORT_OUT_BIT = 0;
  localparam int PORT_DIR_BIT = 1;

  // Waveform generation modes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE = 2'h1;
  localparam logic [1:0] MODE_CLEAR = 2'h2;
  localparam logic [1:0] MODE_FAST = 2'h3;

  // Compare output actions
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  // Tick sources and prescaler terminal counts (cycles minus one)
  localparam logic [2:0] CS_NONE = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] DIV8_LAST = 10'h007;
  localparam logic [9:0] DIV64_LAST = 10'h03F;
  localparam logic [9:0] DIV256_LAST = 10'h0FF;
  localparam logic [9:0] DIV1024_LAST = 10'h3FF;

  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [9:0] PRE_RST = 10'h000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic {BUS_IDLE, BUS_DATA} bus_phase_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ahb_req_t;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } ahb_rsp_t;

  typedef struct packed {
    logic wave_pin_out;
    logic wave_pin_oe;
  } pin_t;

  // Next wave level for a compare match under a given output action
  function automatic logic wave_act(input logic [1:0] com, input logic w);
    case (com)
      COM_TOGGLE: return ~w;
      COM_CLEAR: return 1'b0;
      COM_SET: return 1'b1;
      default: return w;
    endcase
  endfunction

endpackage

// ===== bench/pin_load.sv
// External load on the wave pin.
// Assumes a board pull-down, so an undriven pin reads low.
`timescale 1ns/1ps
`default_nettype none

module pin_load
  import timer8_pkg::*;
(
  input wire timer8_pkg::pin_t pin,
  output logic level
);
  assign level = pin.wave_pin_oe ? pin.wave_pin_out : 1'b0;
endmodule // pin_load

`default_nettype wire

// ===== bench/test_timer8_waveform_generator.sv
// Self-checking bench for the timer waveform block.
// Assumes one AHB-Lite slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
`default_nettype none

module test_timer8_waveform_generator;
  import timer8_pkg::*;
  logic hclk;
  logic hresetn;
  ahb_req_t bus_q;
  ahb_req_t req;
  ahb_rsp_t rsp;
  pin_t pin;
  logic level;
  logic [31:0] rd;
  int fails;
  int checked;
  int hi;
  int tg;

  assign req = {bus_q[$bits(ahb_req_t)-1:1], rsp.hreadyout};
  timer8_waveform_generator dut_u (.hclk(hclk), .hresetn(hresetn), .ahb_req(req),
    .ahb_rsp(rsp), .pin(pin));
  pin_load load_u (.pin(pin), .level(level));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds each phase until hready is sampled high
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd);
    @(posedge hclk);
    bus_q.hsel <= 1'b1;
    bus_q.haddr <= {27'h000_0000, a};
    bus_q.htrans <= HTRANS_NONSEQ;
    bus_q.hwrite <= w;
    bus_q.hsize <= 3'h2;
    do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
    bus_q.htrans <= 2'h0;
    bus_q.hwdata <= wd;
    do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd & m, e);
    chk({31'h0000_0000, rsp.hresp}, {31'h0000_0000, HRESP_OKAY});
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] c,
    input logic [2:0] s, input logic f);
    return {24'h00_0000, f, s, c, m};
  endfunction

  // Samples just before each edge, so n edges give n intervals
  task automatic watch(input int n);
    logic p;
    hi = 0;
    tg = 0;
    p = level;
    repeat (n) begin
      @(posedge hclk);
      hi += int'(level === 1'b1);
      tg += int'(level !== p);
      p = level;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc(STATUS_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    chk({30'h0000_0000, pin}, 32'h0000_0000);
    rdc(5'h14, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("done: reset");
  endtask

  task automatic t_force;
    wr(CTRL_OFS, ctl(MODE_NORMAL, COM_SET, CS_NONE, 1'b1));
    rdc(STATUS_OFS, 32'h0000_0007, 32'h0000_0004);
    chk({31'h0000_0000, level}, 32'h0000_0000);
    wr(PORT_OFS, 32'h0000_0002);
    chk({31'h0000_0000, level}, 32'h0000_0001);
    wr(CTRL_OFS, ctl(MODE_NORMAL, COM_OFF, CS_NONE, 1'b1));
    chk({31'h0000_0000, level}, 32'h0000_0000);
    rdc(STATUS_OFS, 32'h0000_0004, 32'h0000_0004);
    wr(CTRL_OFS, ctl(MODE_FAST, COM_TOGGLE, CS_NONE, 1'b1));
    rdc(STATUS_OFS, 32'h0000_0004, 32'h0000_0004);
    $display("done: force");
  endtask

  task automatic t_ctc;
    logic [2:0] cs_t [5];
    int d_t [5];
    cs_t = '{CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024};
    d_t = '{1, 8, 64, 256, 1024};
    wr(COMPARE_OFS, 32'h0000_0000);
    for (int i = 0; i < 5; i++) begin
      wr(CTRL_OFS, ctl(MODE_CLEAR, COM_TOGGLE, cs_t[i], 1'b0));
      watch(16 * d_t[i]);
      chk(tg, 16);
    end
    wr(CTRL_OFS, ctl(MODE_CLEAR, COM_TOGGLE, CS_DIV1, 1'b0));
    wr(COMPARE_OFS, 32'h0000_0003);
    watch(400);
    chk(tg, 100);
    wr(CTRL_OFS, ctl(MODE_CLEAR, COM_TOGGLE, CS_NONE, 1'b0));
    rdc(STATUS_OFS, 32'h0000_0003, 32'h0000_0002);
    wr(STATUS_OFS, 32'h0000_0003);
    rdc(STATUS_OFS, 32'h0000_0003, 32'h0000_0000);
    // Compare below count must wait for the wrap
    wr(COUNT_OFS, 32'h0000_0005);
    wr(COMPARE_OFS, 32'h0000_0001);
    wr(CTRL_OFS, ctl(MODE_CLEAR, COM_TOGGLE, CS_DIV1, 1'b0));
    repeat (200) @(posedge hclk);
    rdc(STATUS_OFS, 32'h0000_0003, 32'h0000_0000);
    repeat (100) @(posedge hclk);
    rdc(STATUS_OFS, 32'h0000_0003, 32'h0000_0003);
    $display("done: clear on match");
  endtask

  task automatic t_normal;
    wr(CTRL_OFS, ctl(MODE_NORMAL, COM_OFF, CS_NONE, 1'b0));
    wr(STATUS_OFS, 32'h0000_0003);
    wr(COUNT_OFS, 32'h0000_00FD);
    repeat (20) @(posedge hclk);
    rdc(COUNT_OFS, 32'hFFFF_FFFF, 32'h0000_00FD);
    rdc(STATUS_OFS, 32'h0000_0001, 32'h0000_0000);
    wr(CTRL_OFS, ctl(MODE_NORMAL, COM_OFF, CS_DIV1, 1'b0));
    wr(CTRL_OFS, ctl(MODE_NORMAL, COM_OFF, CS_NONE, 1'b0));
    rdc(COUNT_OFS, 32'hFFFF_FFF8, 32'h0000_0000);
    rdc(STATUS_OFS, 32'h0000_0001, 32'h0000_0001);
    $display("done: normal");
  endtask

  task automatic t_fast;
    logic [7:0] c_t [4];
    logic [1:0] m_t [4];
    int e_t [4];
    c_t = '{8'h40, 8'h40, 8'hFF, 8'h00};
    m_t = '{COM_CLEAR, COM_SET, COM_CLEAR, COM_CLEAR};
    e_t = '{130, 382, 512, 2};
    wr(STATUS_OFS, 32'h0000_0003);
    for (int i = 0; i < 4; i++) begin
      wr(COMPARE_OFS, {24'h00_0000, c_t[i]});
      wr(CTRL_OFS, ctl(MODE_FAST, m_t[i], CS_DIV1, 1'b0));
      repeat (300) @(posedge hclk);
      watch(512);
      chk(hi, e_t[i]);
    end
    rdc(STATUS_OFS, 32'h0000_0001, 32'h0000_0001);
    $display("done: fast pwm");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // Tests take about 26k cycles
  initial begin
    #1200us;
    fails++;
    finish_test();
  end

  initial begin
    bus_q = '0;
    hresetn = 1'b0;
    fails = 0;
    checked = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_force();
    t_ctc();
    t_normal();
    t_fast();
    finish_test();
  end
endmodule // test_timer8_waveform_generator

`default_nettype wire
